// ### hw/spi_eeprom_cmd_status.sv
// Serial command front end and status register of a byte-wide serial EEPROM.
// Assumes chip select, serial clock and serial input arrive from the host
// asynchronously; the 10 MHz clock oversamples them through two flip-flops.
`timescale 1ns/100ps
`default_nettype none

module spi_eeprom_cmd_status #(
  parameter int WRITE_CYCLES = eeprom_cmd_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_sel_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic write_protect_n,
  output logic sdo,
  output logic sdo_oe,
  output logic [7:0] device_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and helpers.

  // Command decoder states.
  typedef enum logic [2:0] {
    ST_OPCODE = 3'b000,
    ST_ADDR = 3'b001,
    ST_READ = 3'b010,
    ST_STATUS_OUT = 3'b011,
    ST_STATUS_IN = 3'b100,
    ST_PAGE_DATA = 3'b101,
    ST_IGNORE = 3'b110
  } cmd_state_e;

  // True when the address falls in the range the selector code protects.
  function automatic logic is_protected(input eeprom_cmd_pkg::nv_status_s nv,
                                        input logic [eeprom_cmd_pkg::ADDR_W-1:0] addr);
    case ({nv.sel_hi, nv.sel_lo})
      2'b00: is_protected = 1'b0;
      2'b01: is_protected = (addr >= eeprom_cmd_pkg::PROT_QUARTER);
      2'b10: is_protected = (addr >= eeprom_cmd_pkg::PROT_HALF);
      default: is_protected = 1'b1;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.

  // Two-stage synchronisers for all four asynchronous pins.
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  // Previous synchronised clock level for edge detection.
  logic sclk_prev_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= {chip_sel_n, sclk, sdi, write_protect_n};
      sync2_q <= sync1_q;
    end
  end

  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic wp_n_s;
  assign cs_n_s = sync2_q[3];
  assign sclk_s = sync2_q[2];
  assign sdi_s = sync2_q[1];
  assign wp_n_s = sync2_q[0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // Edges only count while selected, so either idle level works.
  logic rise;
  logic fall;
  assign rise = !cs_n_s && sclk_s && !sclk_prev_q;
  assign fall = !cs_n_s && !sclk_s && sclk_prev_q;

  // Deselect edge detection.
  logic cs_n_prev_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_prev_q <= 1'b1;
    end else begin
      cs_n_prev_q <= cs_n_s;
    end
  end
  logic cs_rise;
  assign cs_rise = cs_n_s && !cs_n_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift and bit counting.

  cmd_state_e state_q;
  logic [7:0] shift_q;                 // Incoming bits, MSB first.
  logic [2:0] bit_q;                   // Bit position within current byte.
  logic [5:0] hdr_q;                   // Header bits seen, saturating at 24.
  logic [7:0] opcode_q;                // Latched opcode.
  logic [eeprom_cmd_pkg::ADDR_W-1:0] addr_q; // Current array address.
  logic [7:0] wr_data_q;               // Status write data byte.
  logic [6:0] page_cnt_q;              // Page bytes loaded, saturating at 64.
  logic byte_aligned_q;                // Frame ended on a whole byte.
  logic [7:0] tx_q;                    // Output shift register.
  logic [2:0] tx_bit_q;                // Output bit index.
  logic out_on_q;                      // Output enabled from first data edge to deselect.

  // Array storage, written when an accepted page write launches at deselect.
  logic [7:0] mem_q [0:(1 << eeprom_cmd_pkg::ADDR_W)-1];
  // Page buffer and mask of loaded locations.
  logic [7:0] page_buf_q [0:eeprom_cmd_pkg::PAGE_BYTES-1];
  logic [eeprom_cmd_pkg::PAGE_BYTES-1:0] page_mask_q;

  logic [7:0] byte_in;
  assign byte_in = {shift_q[6:0], sdi_s};
  logic byte_done;
  assign byte_done = rise && (bit_q == 3'h7);

  // Status bits held by this block.
  eeprom_cmd_pkg::nv_status_s nv_q;
  logic latch_q;
  logic busy;
  logic busy_done;
  logic start_write;
  logic is_status_wr_q;

  // Compose the status byte; reserved bits read zero.
  assign device_status = {nv_q.lock, 3'h0, nv_q.sel_hi, nv_q.sel_lo, latch_q, busy};

  // Shift register, bit counter and header counter; the two counters reset on deselect, the shift register holds.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      hdr_q <= 6'h00;
    end else if (cs_n_s) begin
      bit_q <= 3'h0;
      hdr_q <= 6'h00;
    end else if (rise) begin
      shift_q <= byte_in;
      bit_q <= bit_q + 3'h1;
      if (hdr_q != eeprom_cmd_pkg::HDR_ADDR_BITS) begin
        hdr_q <= hdr_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decoder.

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_OPCODE;
      opcode_q <= 8'h00;
      addr_q <= 15'h0000;
      wr_data_q <= 8'h00;
      page_cnt_q <= 7'h00;
    end else if (cs_n_s) begin
      state_q <= ST_OPCODE;
    end else if (byte_done) begin
      case (state_q)
        ST_OPCODE: begin
          opcode_q <= byte_in;
          page_cnt_q <= 7'h00;
          case (byte_in)
            eeprom_cmd_pkg::OP_ARRAY_READ: state_q <= ST_ADDR;
            eeprom_cmd_pkg::OP_PAGE_WRITE: state_q <= ST_ADDR;
            eeprom_cmd_pkg::OP_STATUS_READ: state_q <= ST_STATUS_OUT;
            eeprom_cmd_pkg::OP_STATUS_WRITE: state_q <= ST_STATUS_IN;
            default: state_q <= ST_IGNORE;
          endcase
        end
        ST_ADDR: begin
          // High byte first; the top bit is dropped.
          if (hdr_q == 6'h0F) begin
            addr_q <= {byte_in[6:0], addr_q[7:0]};
          end else begin
            addr_q <= {addr_q[14:8], byte_in};
            state_q <= (opcode_q == eeprom_cmd_pkg::OP_ARRAY_READ) ? ST_READ : ST_PAGE_DATA;
          end
        end
        ST_READ: begin
          addr_q <= addr_q + 15'h0001;
        end
        ST_STATUS_IN: begin
          wr_data_q <= byte_in;
          state_q <= ST_IGNORE;
        end
        ST_PAGE_DATA: begin
          addr_q[5:0] <= addr_q[5:0] + 6'h01;
          if (page_cnt_q != 7'(eeprom_cmd_pkg::PAGE_BYTES)) begin
            page_cnt_q <= page_cnt_q + 7'h01;
          end
        end
        default: state_q <= state_q;
      endcase
    end
  end

  // Byte alignment flag: set at each whole byte, cleared mid-byte.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_aligned_q <= 1'b0;
    end else if (!cs_n_s && rise) begin
      byte_aligned_q <= (bit_q == 3'h7);
    end
  end

  // Page buffer loading; later bytes overwrite earlier in the same slot.
  always_ff @(posedge clk) begin
    if (!cs_n_s && byte_done && state_q == ST_PAGE_DATA) begin
      page_buf_q[addr_q[5:0]] <= byte_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_mask_q <= 64'h0;
    end else if (!cs_n_s && byte_done && state_q == ST_OPCODE) begin
      page_mask_q <= 64'h0;
    end else if (!cs_n_s && byte_done && state_q == ST_PAGE_DATA) begin
      page_mask_q[addr_q[5:0]] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write launch at deselect.

  // Page write needs the latch, whole bytes, data present, and no protection.
  logic page_ok;
  logic status_ok;
  assign page_ok = (state_q == ST_PAGE_DATA) && byte_aligned_q && (page_cnt_q != 7'h00)
                   && latch_q && !busy && !is_protected(nv_q, addr_q);
  // Status write needs exactly one data byte and the latch, and no lock while write protect is low.
  assign status_ok = (state_q == ST_IGNORE) && (opcode_q == eeprom_cmd_pkg::OP_STATUS_WRITE)
                     && (hdr_q == 6'h10) && latch_q && !busy
                     && !(nv_q.lock && !wp_n_s);
  assign start_write = cs_rise && (page_ok || status_ok);

  // Commit the page to the array at launch.
  always_ff @(posedge clk) begin
    if (cs_rise && page_ok) begin
      for (int i = 0; i < eeprom_cmd_pkg::PAGE_BYTES; i++) begin
        if (page_mask_q[i]) begin
          mem_q[{addr_q[14:6], 6'(i)}] <= page_buf_q[i];
        end
      end
    end
  end

  // Remember which write is running so its completion updates status.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      is_status_wr_q <= 1'b0;
    end else if (start_write) begin
      is_status_wr_q <= status_ok;
    end
  end

  eeprom_busy_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(start_write),
    .busy(busy),
    .done(busy_done)
  );

  // Nonvolatile bits: only selectors and lock take the written byte.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_q <= eeprom_cmd_pkg::NV_RESET;
    end else if (busy_done && is_status_wr_q) begin
      nv_q.lock <= wr_data_q[eeprom_cmd_pkg::ST_LOCK];
      nv_q.sel_hi <= wr_data_q[eeprom_cmd_pkg::ST_SEL_HI];
      nv_q.sel_lo <= wr_data_q[eeprom_cmd_pkg::ST_SEL_LO];
    end
  end

  // Write latch: completion clear wins over a set in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= 1'b0;
    end else if (busy_done) begin
      latch_q <= 1'b0;
    end else if (byte_done && !cs_n_s && state_q == ST_OPCODE) begin
      if (byte_in == eeprom_cmd_pkg::OP_SET_LATCH) begin
        latch_q <= 1'b1;
      end else if (byte_in == eeprom_cmd_pkg::OP_CLEAR_LATCH) begin
        latch_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output path.

  // Load a byte at the first falling edge of a new output byte, then shift.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= 8'h00;
      tx_bit_q <= 3'h0;
      sdo <= 1'b0;
      out_on_q <= 1'b0;
    end else if (cs_n_s) begin
      tx_bit_q <= 3'h0;
      out_on_q <= 1'b0;
    end else if (fall && (state_q == ST_READ || state_q == ST_STATUS_OUT)) begin
      out_on_q <= 1'b1;
      if (tx_bit_q == 3'h0) begin
        tx_q <= (state_q == ST_READ) ? mem_q[addr_q] : device_status;
        sdo <= (state_q == ST_READ) ? mem_q[addr_q][7] : device_status[7];
      end else begin
        sdo <= tx_q[3'h7 - tx_bit_q];
      end
      tx_bit_q <= tx_bit_q + 3'h1;
    end
  end

  // Drive only while selected, without gaps between output bytes.
  assign sdo_oe = !cs_n_s && out_on_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_done;
    busy_done;
  endsequence

  a_latch_clear: assert property (@(posedge clk) disable iff (!reset_n)
    s_done |=> !latch_q) else $error("latch not cleared");
  a_busy_ok: assert property (@(posedge clk) disable iff (!reset_n)
    start_write |=> busy) else $error("busy not raised");
  a_out_off: assert property (@(posedge clk) disable iff (!reset_n)
    cs_n_s |-> !sdo_oe) else $error("output driven while deselected");
  a_resv_zero: assert property (@(posedge clk) disable iff (!reset_n)
    device_status[6:4] == 3'h0) else $error("reserved bits set");
  a_lock_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (cs_rise && nv_q.lock && !wp_n_s) |-> !start_write) else $error("locked status write");
  a_no_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (cs_rise && !latch_q) |-> !start_write) else $error("write without latch");
  a_nv_stable: assert property (@(posedge clk) disable iff (!reset_n)
    !(busy_done && is_status_wr_q) |=> $stable(nv_q)) else $error("nv bits changed");
  a_set_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (byte_done && !cs_n_s && state_q == ST_OPCODE && byte_in == 8'h06 && !busy_done)
    |=> latch_q) else $error("latch not set");

endmodule

`default_nettype wire

// ### hw/eeprom_cmd_pkg.sv
// Constants and carriers shared by the serial EEPROM command front end.
// Assumes a 10 MHz system clock that oversamples the host's serial clock.
package eeprom_cmd_pkg;

  // Command opcodes.
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;

  // Status register field positions.
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_SEL_LO = 2;
  localparam int ST_SEL_HI = 3;
  localparam int ST_LOCK = 7;

  // Array geometry: fifteen address bits, 64-byte pages.
  localparam int ADDR_W = 15;
  localparam int PAGE_BITS = 6;
  localparam int PAGE_BYTES = 64;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 15'h7FFF;

  // Protected range lower bounds for selector codes 01 and 10.
  localparam logic [ADDR_W-1:0] PROT_QUARTER = 15'h6000;
  localparam logic [ADDR_W-1:0] PROT_HALF = 15'h4000;

  // Write cycle time and its cycle count at the 10 MHz clock.
  localparam int CLK_HZ = 10000000;
  localparam int WRITE_TIME_MS = 10;
  localparam int WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);

  // Bit counts within a frame.
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] HDR_ADDR_BITS = 6'h18;

  // Nonvolatile status bits, carried as one group.
  typedef struct packed {
    logic lock;
    logic sel_hi;
    logic sel_lo;
  } nv_status_s;

  localparam nv_status_s NV_RESET = 3'h0;

endpackage

// ### hw/eeprom_busy_timer.sv
// Write cycle timer: raises busy for a programmable number of clocks.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none

module eeprom_busy_timer #(
  parameter int CYCLES = 100000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic busy,
  output logic done
);

  // Remaining cycles of the current write.
  logic [23:0] count_q;

  ////////////////////////////////////////////////////////////////////////////
  // Counter loads on start and counts down to zero.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 24'h000000;
    end else if (start) begin
      count_q <= 24'(CYCLES);
    end else if (count_q != 24'h000000) begin
      count_q <= count_q - 24'h000001;
    end
  end

  // Busy while counting; done pulses on the final count.
  assign busy = (count_q != 24'h000000);
  assign done = (count_q == 24'h000001);

endmodule

`default_nettype wire

// ### verif/spi_host_model.sv
// Host side of the serial link: frames commands and captures the answer.
// Assumes one caller at a time and a device that updates sdo after falling edges.
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
  output logic chip_sel_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic done,
  output logic [47:0] rx_d,
  output logic [47:0] rx_oe
);
  // Start deselected with the clock parked low.
  initial begin
    chip_sel_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    done = 1'b0;
    rx_d = '0;
    rx_oe = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One frame, most significant bit first, 800 ns link period.
  // Output is captured just before each falling edge, where it has settled.
  task automatic frame(input logic [47:0] tx, input int nbits, input bit mode3);
    rx_d = '0;
    rx_oe = '0;
    sclk = mode3;
    #400 chip_sel_n = 1'b0;
    if (mode3) begin
      #400 sclk = 1'b0;
    end
    for (int i = 0; i < nbits; i++) begin
      sdi = tx[47-i];
      #400 sclk = 1'b1;
      // A released output is seen as the inverse of its last value.
      #390 rx_d = {rx_d[46:0], sdo_oe ? sdo : ~sdo};
      rx_oe = {rx_oe[46:0], sdo_oe};
      // In mode 3 the clock stays high after the last bit, so no extra edges follow.
      #10 if (!mode3 || i < nbits - 1) begin
        sclk = 1'b0;
      end
    end
    #400 sclk = mode3;
    #400 chip_sel_n = 1'b1;
    // A released input is not left at its last value.
    sdi = ~sdi;
    #500 done = 1'b1;
    #100 done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/spi_eeprom_cmd_status_test.sv
// Self-checking bench for the serial EEPROM command front end.
// Assumes the host model above and a shortened write cycle count.
`timescale 1ns/100ps
`default_nettype none

module spi_eeprom_cmd_status_test;
  localparam int WC = 400; // Shortened write cycle, long enough to poll while busy.
  localparam int LIMIT = 40000; // Cycle ceiling for the whole run.
  // Expected outcome of one frame, with masks for the bits that matter.
  typedef struct packed {
    logic [47:0] d;
    logic [47:0] dm;
    logic [47:0] oe;
    logic [47:0] om;
    logic [7:0] st;
  } note_s;
  logic clk, reset_n, write_protect_n, chip_sel_n, sclk, sdi, sdo, sdo_oe, done;
  logic [7:0] device_status;
  logic [47:0] rx_d, rx_oe;
  note_s q[$];
  int failures, n_tests, cycles;
  logic [7:0] rnd, base;

  spi_eeprom_cmd_status #(.WRITE_CYCLES(WC)) dut (.clk(clk), .reset_n(reset_n),
    .chip_sel_n(chip_sel_n), .sclk(sclk), .sdi(sdi), .write_protect_n(write_protect_n),
    .sdo(sdo), .sdo_oe(sdo_oe), .device_status(device_status));
  spi_host_model host (.chip_sel_n(chip_sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .done(done), .rx_d(rx_d), .rx_oe(rx_oe));

  // 10 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparisons.
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Serial capture compared under a mask.
  task automatic cmp_vec(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Live status byte.
  task automatic cmp_stat(input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] device_status expected %h seen %h", exp, got);
    end
  endtask

  // Hang guard: a run past the ceiling counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      close_out();
    end
  end

  // Watcher: each finished frame takes the oldest note and checks it.
  initial begin
    note_s n;
    forever begin
      @(posedge done);
      if (q.size() == 0) begin
        cmp_vec("note_queue", 48'h1, 48'h0);
      end else begin
        n = q.pop_front();
        cmp_vec("serial_data", n.d & n.dm, rx_d & n.dm);
        cmp_vec("output_enable", n.oe & n.om, rx_oe & n.om);
        cmp_stat(n.st, device_status);
        cmp_vec("release", 48'h0, {47'h0, sdo_oe});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver side: note the expectation, then run the frame.
  task automatic send(input logic [47:0] tx, input int nbits, input bit m3, input logic [47:0] d,
                      input logic [47:0] dm, input logic [47:0] oe, input logic [47:0] om,
                      input logic [7:0] st);
    q.push_back('{d, dm, oe, om, st});
    @(posedge clk);
    // The frame pulses done itself before it returns; waiting for it again would hang.
    #2 host.frame(tx, nbits, m3);
  endtask

  // One-byte command; only the status byte and the output release are checked.
  task automatic cmd(input logic [7:0] op, input logic [7:0] st);
    send({op, 40'h0}, 8, 1'b0, '0, '0, '0, '0, st);
  endtask

  // Status read of three bytes: opcode, then the status twice.
  task automatic rd_status(input bit m3, input logic [7:0] st, input logic [47:0] dm);
    send({eeprom_cmd_pkg::OP_STATUS_READ, 40'h0}, 24, m3, {32'h0, st, st}, dm,
         48'h00FFFF, 48'hFFFFFF, st);
  endtask

  // Status write with a chosen bit count.
  task automatic wr_status(input logic [15:0] v, input int nbits, input logic [7:0] st);
    send({eeprom_cmd_pkg::OP_STATUS_WRITE, v, 24'h0}, nbits, 1'b0, '0, '0, '0, '0, st);
  endtask

  // Input change a fixed small delay after the clock edge.
  task automatic set_wp(input logic v);
    @(posedge clk);
    #2 write_protect_n = v;
  endtask

  // Byte-wide pseudo-random source.
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    write_protect_n = 1'b1;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    rnd = 8'h2F;
    repeat (8) @(posedge clk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge clk);
    rd_status(1'b0, 8'h00, 48'hFFFF);
    cmd(eeprom_cmd_pkg::OP_SET_LATCH, 8'h02);
    rd_status(1'b1, 8'h02, 48'hFFFF);
    cmd(eeprom_cmd_pkg::OP_CLEAR_LATCH, 8'h00);
    wr_status(16'h8C00, 16, 8'h00);
    cmd(eeprom_cmd_pkg::OP_SET_LATCH, 8'h02);
    wr_status(16'hFF00, 16, 8'h03);
    rd_status(1'b0, 8'h03, 48'hFF00);
    repeat (WC + 20) @(posedge clk);
    rd_status(1'b0, 8'h8C, 48'hFFFF);
    cmd(eeprom_cmd_pkg::OP_SET_LATCH, 8'h8E);
    set_wp(1'b0);
    wr_status(16'h0000, 16, 8'h8E);
    set_wp(1'b1);
    wr_status(16'h0000, 12, 8'h8E);
    wr_status(16'h0000, 24, 8'h8E);
    // Array read from a random address with the ignored top bit set.
    rnd = lfsr(rnd);
    send({eeprom_cmd_pkg::OP_ARRAY_READ, 1'b1, rnd[6:0], rnd, 24'h0}, 40, 1'b0, '0, '0,
         48'hFFFF, 48'hFF_FFFF_FFFF, 8'h8E);
    // Open the whole array, then write a page that wraps inside its low six address bits.
    wr_status(16'h0000, 16, 8'h8F);
    repeat (WC + 20) @(posedge clk);
    cmd(eeprom_cmd_pkg::OP_SET_LATCH, 8'h02);
    send({eeprom_cmd_pkg::OP_PAGE_WRITE, 16'h123E, 24'hA1B2C3}, 48, 1'b0, '0, '0, '0, '0,
         8'h03);
    repeat (WC + 20) @(posedge clk);
    // Read back with the ignored top address bit set; the third byte wrapped to offset 0.
    send({eeprom_cmd_pkg::OP_ARRAY_READ, 16'h923E, 24'h0}, 48, 1'b0, {24'h0, 16'hA1B2, 8'h00},
         48'h0000_00FF_FF00, 48'hFF_FFFF, 48'hFF_FFFF, 8'h00);
    send({eeprom_cmd_pkg::OP_ARRAY_READ, 16'h1200, 24'h0}, 32, 1'b0, 48'hC3, 48'hFF, '0, '0,
         8'h00);
    // A page write cut mid-byte is dropped and keeps the latch.
    cmd(eeprom_cmd_pkg::OP_SET_LATCH, 8'h02);
    send({eeprom_cmd_pkg::OP_PAGE_WRITE, 16'h1200, 24'h5A0000}, 36, 1'b0, '0, '0, '0, '0,
         8'h02);
    send({eeprom_cmd_pkg::OP_ARRAY_READ, 16'h1200, 24'h0}, 32, 1'b0, 48'hC3, 48'hFF, '0, '0,
         8'h02);
    base = 8'h00;
    // Random status writes: only selectors and lock may take effect.
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      cmd(eeprom_cmd_pkg::OP_SET_LATCH, base | 8'h02);
      wr_status({rnd, 8'h00}, 16, base | 8'h03);
      repeat (WC + 20) @(posedge clk);
      base = {rnd[7], 3'b000, rnd[3:2], 2'b00};
      rd_status(1'b0, base, 48'hFFFF);
    end
    repeat (10) @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
